// [core/tsc_pkg.sv]
// Package for the transmit bus parity and start-marker checker.
// Assumes one clock that is the transmit FIFO clock of the system bus.
`default_nettype none

package tsc_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CH_W = 2;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned POS_W = 5;
  localparam int unsigned CELL_OCTETS = 53;
  // 16-bit bus carries the 53 octets plus one pad octet
  localparam logic [POS_W-1:0] CELL_WORDS = POS_W'((CELL_OCTETS + 1) / 2);
  localparam logic [POS_W-1:0] LAST_WORD = CELL_WORDS - 5'h01;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT_MAP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_POS = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_PKT_BIT = 0;
  localparam int unsigned CTRL_ODD_LSB = 4;
  localparam int unsigned STAT_PERR_LSB = 0;
  localparam int unsigned STAT_SOC_LSB = 4;
  localparam int unsigned STAT_PKT_LSB = 8;
  localparam int unsigned MASK_PERR_LSB = 0;
  localparam int unsigned MASK_SOC_LSB = 4;
  localparam int unsigned MAP_STRIDE = 8;

  // ==========================================================================
  // Values after reset
  localparam logic CTRL_PKT_RST = 1'b0;
  localparam logic [NUM_CH-1:0] CTRL_ODD_RST = 4'h0;
  localparam logic [NUM_CH*ADDR_W-1:0] PORT_MAP_RST = 20'h18820;
  localparam logic [NUM_CH-1:0] MASK_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h1F;
  localparam logic [POS_W-1:0] POS_RST = 5'h00;

endpackage : tsc_pkg

`default_nettype wire

// [core/tsc_parity_chk.sv]
// Parity check of one transmit bus word against its parity bit.
// Assumes word and parity bit come from the same bus cycle.
`default_nettype none

module tsc_parity_chk (
  // Bus word
  input wire logic [tsc_pkg::WORD_W-1:0] word_i,
  input wire logic parity_i,
  // Odd parity when high, even when low
  input wire logic odd_sel_i,
  // Mismatch, combinational
  output logic mismatch_o
);

  // ==========================================================================
  // Check
  // Even: ones over word and bit even; odd: ones count odd
  assign mismatch_o = (^{word_i, parity_i}) ^ odd_sel_i;

endmodule : tsc_parity_chk

`default_nettype wire

// [core/tsc_pos_ctr.sv]
// Word position counter of one channel within the current cell.
// Assumes take_i is high once for each word written to this channel.
`default_nettype none

module tsc_pos_ctr (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Word taken and its start marker
  input wire logic take_i,
  input wire logic start_i,
  // Position of the next word
  output logic [tsc_pkg::POS_W-1:0] pos_o,
  // Combinational events of the taken word
  output logic first_o,
  output logic misplaced_o,
  output logic cell_end_o
);

  typedef struct packed {
    logic [tsc_pkg::POS_W-1:0] pos;
  } tsc_ctr_st_t;

  tsc_ctr_st_t s_r;
  tsc_ctr_st_t s_nxt;
  logic [tsc_pkg::POS_W-1:0] idx;

  // ==========================================================================
  // Index of the word now on the bus
  // A marker always resynchronises, a missing one lets the count run on
  assign idx = start_i ? tsc_pkg::POS_RST : s_r.pos;
  assign first_o = take_i && (idx == tsc_pkg::POS_RST);
  assign misplaced_o = take_i && start_i && (s_r.pos != tsc_pkg::POS_RST);
  assign cell_end_o = take_i && (idx == tsc_pkg::LAST_WORD);
  assign pos_o = s_r.pos;

  // Next state
  always_comb begin
    s_nxt = s_r;
    if (take_i) begin
      s_nxt.pos = (idx == tsc_pkg::LAST_WORD) ? tsc_pkg::POS_RST : idx + 5'h01;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{pos: tsc_pkg::POS_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : tsc_pos_ctr

`default_nettype wire

// [core/tsc_top.sv]
// Transmit system bus sideband checker: parity, cell start and packet start.
// Assumes the bus master drives all bus inputs synchronously to clock_i,
// the transmit FIFO clock, and that an APB master reaches the registers.
//
// The address map and the APB interface to the registers were decided locally.
`default_nettype none

module tsc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Transmit system bus
  input wire logic [tsc_pkg::WORD_W-1:0] tx_word_bus_i,
  input wire logic tx_bus_parity_in_i,
  input wire logic tx_cell_start_marker_i,
  input wire logic tx_packet_start_marker_i,
  input wire logic tx_write_enable_n_i,
  input wire logic [tsc_pkg::ADDR_W-1:0] tx_port_select_i,
  // Word stream towards the transmit FIFOs
  output logic fifo_wr_o,
  output logic [tsc_pkg::WORD_W-1:0] fifo_word_o,
  output logic [tsc_pkg::CH_W-1:0] fifo_chan_o,
  output logic fifo_first_o,
  output logic fifo_par_err_o,
  output logic fifo_cell_done_o,
  // Interrupt
  output logic irq_o
);

  typedef struct packed {
    logic pkt_mode;
    logic [tsc_pkg::NUM_CH-1:0] par_odd;
    logic [tsc_pkg::NUM_CH*tsc_pkg::ADDR_W-1:0] port_map;
    logic [tsc_pkg::NUM_CH-1:0] st_perr;
    logic [tsc_pkg::NUM_CH-1:0] st_soc;
    logic [tsc_pkg::NUM_CH-1:0] st_pkt;
    logic [tsc_pkg::NUM_CH-1:0] mask_perr;
    logic [tsc_pkg::NUM_CH-1:0] mask_soc;
    logic [tsc_pkg::ADDR_W-1:0] lat_addr;
    logic [31:0] prdata;
    logic pslverr;
    logic wr;
    logic [tsc_pkg::WORD_W-1:0] word;
    logic [tsc_pkg::CH_W-1:0] chan;
    logic first;
    logic par_err;
    logic cell_done;
    logic irq;
  } tsc_st_t;

  tsc_st_t s_r;
  tsc_st_t s_nxt;

  // ==========================================================================
  // Register map, one 32-bit word each, byte offsets from the package
  //   CTRL      bit 0 packet mode; bits 7:4 odd parity per channel
  //   PORT_MAP  bus address of channel i in bits 8i+4:8i
  //   STATUS    write one to clear; parity, misplaced start, packet start
  //   MASK      bits 3:0 parity irq enable; bits 7:4 misplaced irq enable
  //   POS       read only; next word index of each channel
  // Unmapped offsets answer with pslverr and read as zero.
  // No wait states: read data is loaded in the setup cycle, so a read
  // returns state as it stood one cycle before the access phase.
  // After reset: cell mode, even parity, channel i at address i, masks off.
  // Latched address resets to an unmapped value, so no word is taken
  // before the master has selected a channel once.
  //
  // Bus timing, one clock per word
  //   Edge with enable high: address latched, nothing written
  //   Edge with enable low and a channel hit: word taken
  //   One edge later: stream outputs pulse, status and irq updated
  // Two channels mapped to one address: the lowest one takes the word,
  // the other sees no traffic until the map is fixed.
  //
  // Status bits are sticky; a write-one-to-clear meeting a new event
  // in the same cycle leaves the bit set, so no event is ever lost.
  // Interrupt is a level, the OR of the unmasked parity and misplaced status bits,
  // registered so it carries no glitch from the bus inputs.
  //
  // Cell mode keeps a word index per channel; a start marker forces
  // index zero, and if the index was not zero the marker is flagged
  // as misplaced but still obeyed, so the channel resyncs at once.
  // Without markers the index simply wraps after the last word.
  // Packet mode stops the counters; boundaries rest only on the
  // packet start marker, which the master must give on every packet.
  // Words with bad parity are never dropped; the flag travels with them.

  // ==========================================================================
  // Channel lookup
  // Returns hit bit above the channel index; lowest channel wins a tie
  function automatic logic [tsc_pkg::CH_W:0] chan_lookup(
    input logic [tsc_pkg::ADDR_W-1:0] addr,
    input logic [tsc_pkg::NUM_CH*tsc_pkg::ADDR_W-1:0] map
  );
    logic [tsc_pkg::CH_W:0] res;
    res = '0;
    for (int i = tsc_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (map[i*tsc_pkg::ADDR_W +: tsc_pkg::ADDR_W] == addr) begin
        res = {1'b1, tsc_pkg::CH_W'(i)};
      end
    end
    return res;
  endfunction : chan_lookup

  logic [tsc_pkg::CH_W:0] look;
  logic sel_hit;
  logic [tsc_pkg::CH_W-1:0] sel_ch;
  logic bus_valid;
  logic par_bad;
  logic [tsc_pkg::NUM_CH-1:0] take;
  logic [tsc_pkg::NUM_CH-1:0] ch_first;
  logic [tsc_pkg::NUM_CH-1:0] ch_misplaced;
  logic [tsc_pkg::NUM_CH-1:0] ch_cell_end;
  logic [tsc_pkg::NUM_CH*tsc_pkg::POS_W-1:0] ch_pos;

  // ==========================================================================
  // Bus qualification
  // Write goes to the address latched while enable was high
  assign look = chan_lookup(s_r.lat_addr, s_r.port_map);
  assign sel_hit = look[tsc_pkg::CH_W];
  assign sel_ch = look[tsc_pkg::CH_W-1:0];
  // Plain sampling: bus is on this clock, no synchroniser needed
  assign bus_valid = !tx_write_enable_n_i && sel_hit;

  // Parity of the word against the selected channel's type
  tsc_parity_chk u_par (
    .word_i(tx_word_bus_i),
    .parity_i(tx_bus_parity_in_i),
    .odd_sel_i(s_r.par_odd[sel_ch]),
    .mismatch_o(par_bad)
  );

  // ==========================================================================
  // Per-channel cell position
  generate
    for (genvar g = 0; g < tsc_pkg::NUM_CH; g++) begin : g_ch
      // Counters only run in cell mode
      assign take[g] = bus_valid && !s_r.pkt_mode && (sel_ch == tsc_pkg::CH_W'(g));
      tsc_pos_ctr u_pos (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .take_i(take[g]),
        .start_i(tx_cell_start_marker_i),
        .pos_o(ch_pos[g*tsc_pkg::POS_W +: tsc_pkg::POS_W]),
        .first_o(ch_first[g]),
        .misplaced_o(ch_misplaced[g]),
        .cell_end_o(ch_cell_end[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Next state: registers, events, stream and interrupt
  always_comb begin
    s_nxt = s_r;
    // APB setup phase: read data and error loaded for the access phase
    if (psel_i && !penable_i) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      if (paddr_i == tsc_pkg::OFS_CTRL) begin
        s_nxt.prdata[tsc_pkg::CTRL_PKT_BIT] = s_r.pkt_mode;
        s_nxt.prdata[tsc_pkg::CTRL_ODD_LSB +: tsc_pkg::NUM_CH] = s_r.par_odd;
      end else if (paddr_i == tsc_pkg::OFS_PORT_MAP) begin
        for (int i = 0; i < tsc_pkg::NUM_CH; i++) begin
          s_nxt.prdata[i*tsc_pkg::MAP_STRIDE +: tsc_pkg::ADDR_W] =
            s_r.port_map[i*tsc_pkg::ADDR_W +: tsc_pkg::ADDR_W];
        end
      end else if (paddr_i == tsc_pkg::OFS_STATUS) begin
        s_nxt.prdata[tsc_pkg::STAT_PERR_LSB +: tsc_pkg::NUM_CH] = s_r.st_perr;
        s_nxt.prdata[tsc_pkg::STAT_SOC_LSB +: tsc_pkg::NUM_CH] = s_r.st_soc;
        s_nxt.prdata[tsc_pkg::STAT_PKT_LSB +: tsc_pkg::NUM_CH] = s_r.st_pkt;
      end else if (paddr_i == tsc_pkg::OFS_MASK) begin
        s_nxt.prdata[tsc_pkg::MASK_PERR_LSB +: tsc_pkg::NUM_CH] = s_r.mask_perr;
        s_nxt.prdata[tsc_pkg::MASK_SOC_LSB +: tsc_pkg::NUM_CH] = s_r.mask_soc;
      end else if (paddr_i == tsc_pkg::OFS_POS) begin
        for (int i = 0; i < tsc_pkg::NUM_CH; i++) begin
          s_nxt.prdata[i*tsc_pkg::MAP_STRIDE +: tsc_pkg::POS_W] =
            ch_pos[i*tsc_pkg::POS_W +: tsc_pkg::POS_W];
        end
      end else begin
        s_nxt.pslverr = 1'b1; // Unmapped address
      end
    end
    // APB access phase write; no wait states, so pready is always high
    if (psel_i && penable_i && pwrite_i && !s_r.pslverr) begin
      if (paddr_i == tsc_pkg::OFS_CTRL) begin
        s_nxt.pkt_mode = pwdata_i[tsc_pkg::CTRL_PKT_BIT];
        s_nxt.par_odd = pwdata_i[tsc_pkg::CTRL_ODD_LSB +: tsc_pkg::NUM_CH];
      end else if (paddr_i == tsc_pkg::OFS_PORT_MAP) begin
        for (int i = 0; i < tsc_pkg::NUM_CH; i++) begin
          s_nxt.port_map[i*tsc_pkg::ADDR_W +: tsc_pkg::ADDR_W] =
            pwdata_i[i*tsc_pkg::MAP_STRIDE +: tsc_pkg::ADDR_W];
        end
      end else if (paddr_i == tsc_pkg::OFS_STATUS) begin
        // Write one to clear
        s_nxt.st_perr = s_r.st_perr & ~pwdata_i[tsc_pkg::STAT_PERR_LSB +: tsc_pkg::NUM_CH];
        s_nxt.st_soc = s_r.st_soc & ~pwdata_i[tsc_pkg::STAT_SOC_LSB +: tsc_pkg::NUM_CH];
        s_nxt.st_pkt = s_r.st_pkt & ~pwdata_i[tsc_pkg::STAT_PKT_LSB +: tsc_pkg::NUM_CH];
      end else if (paddr_i == tsc_pkg::OFS_MASK) begin
        s_nxt.mask_perr = pwdata_i[tsc_pkg::MASK_PERR_LSB +: tsc_pkg::NUM_CH];
        s_nxt.mask_soc = pwdata_i[tsc_pkg::MASK_SOC_LSB +: tsc_pkg::NUM_CH];
      end
    end
    // Address is latched only while enable is high
    if (tx_write_enable_n_i) begin
      s_nxt.lat_addr = tx_port_select_i;
    end
    // Events set after the clear so a same-cycle event survives
    for (int i = 0; i < tsc_pkg::NUM_CH; i++) begin
      if (bus_valid && (sel_ch == tsc_pkg::CH_W'(i))) begin
        if (par_bad) begin
          s_nxt.st_perr[i] = 1'b1;
        end
        if (s_r.pkt_mode && tx_packet_start_marker_i) begin
          s_nxt.st_pkt[i] = 1'b1;
        end
      end
      if (ch_misplaced[i]) begin
        s_nxt.st_soc[i] = 1'b1;
      end
    end
    // Stream: every qualified word passes, bad parity only flagged
    s_nxt.wr = bus_valid;
    s_nxt.word = tx_word_bus_i;
    s_nxt.chan = sel_ch;
    s_nxt.par_err = bus_valid && par_bad;
    if (s_r.pkt_mode) begin
      // Packet boundaries rest on the master marking each packet start
      s_nxt.first = bus_valid && tx_packet_start_marker_i;
      s_nxt.cell_done = 1'b0;
    end else begin
      s_nxt.first = |ch_first;
      // Downstream sends idle cells until this pulse marks a whole cell
      s_nxt.cell_done = |ch_cell_end;
    end
    // One masked interrupt from the sticky bits
    s_nxt.irq = |((s_nxt.st_perr & s_nxt.mask_perr) |
                  (s_nxt.st_soc & s_nxt.mask_soc));
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{
        pkt_mode: tsc_pkg::CTRL_PKT_RST,
        par_odd: tsc_pkg::CTRL_ODD_RST,
        port_map: tsc_pkg::PORT_MAP_RST,
        st_perr: '0,
        st_soc: '0,
        st_pkt: '0,
        mask_perr: tsc_pkg::MASK_RST,
        mask_soc: tsc_pkg::MASK_RST,
        lat_addr: tsc_pkg::ADDR_RST,
        default: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // Error gated by the access phase so it never shows outside a transfer
  assign prdata_o = s_r.prdata;
  assign pslverr_o = s_r.pslverr && psel_i && penable_i;
  assign pready_o = 1'b1;
  assign fifo_wr_o = s_r.wr;
  assign fifo_word_o = s_r.word;
  assign fifo_chan_o = s_r.chan;
  assign fifo_first_o = s_r.first;
  assign fifo_par_err_o = s_r.par_err;
  assign fifo_cell_done_o = s_r.cell_done;
  assign irq_o = s_r.irq;

endmodule : tsc_top

`default_nettype wire

// [dv/tsc_props.sv]
// Checker of the sideband checker's bus and interrupt behaviour.
// Assumes the default port map (channel i answers address i).
`default_nettype none

module tsc_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // APB
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  // Transmit bus
  input wire logic [15:0] tx_word_bus_i,
  input wire logic tx_bus_parity_in_i,
  input wire logic tx_cell_start_marker_i,
  input wire logic tx_packet_start_marker_i,
  input wire logic tx_write_enable_n_i,
  input wire logic [4:0] tx_port_select_i,
  // Outputs
  input wire logic fifo_wr_o,
  input wire logic [15:0] fifo_word_o,
  input wire logic [1:0] fifo_chan_o,
  input wire logic fifo_first_o,
  input wire logic fifo_par_err_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Helper state
  logic [4:0] lat_r;
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic take;
  logic exp_err;
  logic apb_wr;
  // Shadow of address latch and the two registers that shape outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_r <= 5'h1F;
      ctrl_r <= 8'h00;
      mask_r <= 8'h00;
    end else begin
      if (tx_write_enable_n_i) lat_r <= tx_port_select_i;
      if (apb_wr && paddr_i == 8'h00) ctrl_r <= pwdata_i[7:0];
      if (apb_wr && paddr_i == 8'h0C) mask_r <= pwdata_i[7:0];
    end
  end
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign take = !tx_write_enable_n_i && (lat_r < 5'h04);
  assign exp_err = (^{tx_word_bus_i, tx_bus_parity_in_i}) ^ ctrl_r[4 + lat_r[1:0]];

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wr_take_a: assert property (take |=> fifo_wr_o && fifo_chan_o == $past(lat_r[1:0])
    && fifo_word_o == $past(tx_word_bus_i)) else $error("selected word not written");
  no_stray_wr_a: assert property (!take |=> !fifo_wr_o)
    else $error("write without enable and select");
  par_flag_a: assert property (take |=> fifo_par_err_o == $past(exp_err))
    else $error("parity flag wrong");
  bad_pass_a: assert property (take && exp_err |=> fifo_wr_o)
    else $error("bad parity word dropped");
  first_mark_a: assert property (take && (ctrl_r[0] ? tx_packet_start_marker_i
    : tx_cell_start_marker_i) |=> fifo_first_o) else $error("marker not first");
  irq_raise_a: assert property (fifo_wr_o && fifo_par_err_o && mask_r[fifo_chan_o]
    && !apb_wr |=> irq_o) else $error("parity irq missing");
  irq_mask_a: assert property (mask_r == 8'h00 && !apb_wr |=> !irq_o)
    else $error("masked irq raised");
  irq_hold_a: assert property (irq_o && !apb_wr |=> irq_o)
    else $error("irq dropped without clear");
  cover property (take && exp_err);
  cover property (take && !ctrl_r[0] && tx_cell_start_marker_i);
  cover property (take && ctrl_r[0] && tx_packet_start_marker_i);
endmodule : tsc_props

bind tsc_top tsc_props tsc_props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i), .tx_word_bus_i(tx_word_bus_i), .tx_bus_parity_in_i(tx_bus_parity_in_i),
  .tx_cell_start_marker_i(tx_cell_start_marker_i), .tx_port_select_i(tx_port_select_i),
  .tx_packet_start_marker_i(tx_packet_start_marker_i), .fifo_wr_o(fifo_wr_o),
  .tx_write_enable_n_i(tx_write_enable_n_i), .fifo_word_o(fifo_word_o),
  .fifo_chan_o(fifo_chan_o), .fifo_first_o(fifo_first_o),
  .fifo_par_err_o(fifo_par_err_o), .irq_o(irq_o));

`default_nettype wire

// [dv/tsc_master_model.sv]
// Bus master model driving the transmit system bus.
// Assumes clock_i is the transmit FIFO clock; tasks run from the bench.
`default_nettype none

module tsc_master_model (
  // Clock
  input wire logic clock_i,
  // Transmit bus
  output logic [15:0] word_o,
  output logic par_o,
  output logic cell_mk_o,
  output logic pkt_mk_o,
  output logic en_n_o,
  output logic [4:0] sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    {word_o, par_o, cell_mk_o, pkt_mk_o, sel_o} = '0;
    en_n_o = 1'b1;
  end
  // ==========================================================================
  // One select cycle, then n back-to-back words; marker at mk, bad parity at bad
  task automatic burst(input logic [4:0] port, input int n, input int mk, input int bad,
                       input logic odd);
    logic [15:0] w;
    @(posedge clock_i);
    sel_o <= port;
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      w = 16'($urandom);
      en_n_o <= 1'b0;
      word_o <= w;
      par_o <= ^w ^ odd ^ (i == bad);
      cell_mk_o <= (i == mk);
      pkt_mk_o <= (i == mk);
    end
    @(posedge clock_i);
    // Released word, marker and select lines flip and enable goes high, so that stale values never look valid
    en_n_o <= 1'b1;
    word_o <= ~word_o;
    cell_mk_o <= ~cell_mk_o;
    pkt_mk_o <= ~pkt_mk_o;
    sel_o <= ~sel_o;
    // Bench model digests the last word before any check reads it
    @(negedge clock_i);
  endtask : burst
endmodule : tsc_master_model

`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench: reference model against the sideband checker.
// Assumes the default port map and a 10 MHz clock.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, par, cmk, pmk, en_n, wr, first, perr, done, irq, f, d;
  logic [15:0] word, fword;
  logic [4:0] sel;
  logic [1:0] fchan;
  int n_fail = 0, total_checks = 0, stat_m = 0, mask_m = 0, ctrl_m = 0, lat_m = 31, e, c;
  int pos[4];
  int q[$];
  always #50 clock_i = ~clock_i;

  tsc_top tsc_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_word_bus_i(word),
    .tx_bus_parity_in_i(par), .tx_cell_start_marker_i(cmk), .tx_packet_start_marker_i(pmk),
    .tx_write_enable_n_i(en_n), .tx_port_select_i(sel), .fifo_wr_o(wr), .fifo_word_o(fword),
    .fifo_chan_o(fchan), .fifo_first_o(first), .fifo_par_err_o(perr),
    .fifo_cell_done_o(done), .irq_o(irq));
  tsc_master_model tsc_master_model_inst (.clock_i(clock_i), .word_o(word), .par_o(par),
    .cell_mk_o(cmk), .pkt_mk_o(pmk), .en_n_o(en_n), .sel_o(sel));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // Master waits for pready, never for a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
    @(posedge clock_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, dw};
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    // Only the watchdog ends a wait that never gets an answer
    while (pready !== 1'b1) @(posedge clock_i);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd === exp && er === (a > 8'h10), "register read");
    chk(irq === (|(stat_m & mask_m & 32'hFF)), "irq level");
  endtask : rchk
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Reference model: compare last edge's prediction, then predict this one
  always @(posedge clock_i) begin
    if (wr === 1'b1 || q.size() > 0) begin
      e = (q.size() > 0) ? q.pop_front() : -1;
      chk(wr === 1'b1 && e == {done, first, perr, fchan, fword}, "fifo word");
    end
    if (rst_n_i && en_n) lat_m = sel;
    else if (rst_n_i && lat_m < 4) begin
      c = lat_m;
      e = (^{word, par}) ^ ctrl_m[4 + c];
      if (e[0]) stat_m |= 1 << c;
      if (ctrl_m[0]) begin
        if (pmk) stat_m |= 1 << (8 + c);
        q.push_back({1'b0, pmk, e[0], c[1:0], word});
      end else begin
        if (cmk && pos[c] != 0) stat_m |= 1 << (4 + c);
        f = cmk || pos[c] == 0;
        pos[c] = cmk ? 1 : pos[c] + 1;
        d = pos[c] == int'(tsc_pkg::CELL_WORDS);
        if (d) pos[c] = 0;
        q.push_back({d, f, e[0], c[1:0], word});
      end
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(68));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h03020100);
    rchk(8'h08, 32'h0);
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    // Random parity sense per channel, error in second word of each
    ctrl_m = $urandom & 32'hF0;
    apb(1'b1, 8'h00, ctrl_m);
    mask_m = 32'h0F;
    apb(1'b1, 8'h0C, mask_m);
    for (int k = 0; k < 4; k++) tsc_master_model_inst.burst(5'(k), 3, 0, 1, ctrl_m[4 + k]);
    rchk(8'h08, stat_m);
    apb(1'b1, 8'h08, 32'hFFF);
    stat_m = 0;
    rchk(8'h08, 32'h0);
    // Masked parity error, then whole cells with and without marker
    mask_m = 32'h40;
    apb(1'b1, 8'h0C, mask_m);
    tsc_master_model_inst.burst(5'h01, 2, -1, 0, ctrl_m[5]);
    rchk(8'h08, stat_m);
    tsc_master_model_inst.burst(5'h02, 27, 0, -1, ctrl_m[6]);
    tsc_master_model_inst.burst(5'h02, 27, -1, -1, ctrl_m[6]);
    // Clear first, so only the misplaced marker below can set the bit
    apb(1'b1, 8'h08, 32'hFFF);
    stat_m = 0;
    tsc_master_model_inst.burst(5'h02, 5, 3, -1, ctrl_m[6]);
    rchk(8'h10, pos[0] | (pos[1] << 8) | (pos[2] << 16) | (pos[3] << 24));
    rchk(8'h08, stat_m);
    // Unselected port must be ignored
    tsc_master_model_inst.burst(5'h07, 4, 0, 0, 1'b0);
    // Packet mode
    ctrl_m |= 1;
    apb(1'b1, 8'h00, ctrl_m);
    tsc_master_model_inst.burst(5'h03, 4, 0, 2, ctrl_m[7]);
    rchk(8'h08, stat_m);
    report_and_stop();
  end
  // Watchdog at 5000 cycles, well beyond the couple of hundred cycles the tests need
  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
